// ==== rtl/mxp_pkg.sv ====
package mxp_pkg;
	localparam int ADDR_HALF_W = 16;
	localparam int DATA_W = 16;
	localparam int WORD_ADDR_W = 32;
	localparam int UPPER_PIN_W = 13;
	localparam int WAIT_W = 4;
	localparam logic [ADDR_HALF_W-1:0] UPPER_RESET_BOTTOM = 16'h0000;
	localparam logic [ADDR_HALF_W-1:0] UPPER_RESET_TOP = 16'hFFFF;
	localparam logic [WAIT_W-1:0] WAIT_STATES_DEFAULT = 4'h4;
	localparam int HOST_CLK_DIV = 2;
	typedef enum logic [1:0] {MXP_ASYNC, MXP_SYNC} mxp_access_type;
	typedef enum logic {MXP_SPLIT, MXP_FULL} mxp_addr_mode_type;

	// Joins upper and lower halves into a word address
	function automatic logic [WORD_ADDR_W-1:0] mxp_join(input logic [ADDR_HALF_W-1:0] hi,
		input logic [ADDR_HALF_W-1:0] lo);
		mxp_join = {hi, lo};
	endfunction
endpackage

// ==== rtl/mxp_if.sv ====
interface mxp_if;
	import mxp_pkg::*;
	logic link_clk;
	logic chip_select_n;
	logic output_enable_n;
	logic write_enable_n;
	logic address_valid_n;
	logic reset_n;
	logic ready;
	logic [UPPER_PIN_W-1:0] upper_address_pins;
	logic [DATA_W-1:0] host_bus_out;
	logic host_bus_oe;
	logic [DATA_W-1:0] dev_bus_out;
	logic dev_bus_oe;
	wire [DATA_W-1:0] muxed_addr_data_bus;
	assign muxed_addr_data_bus = dev_bus_oe ? dev_bus_out : (host_bus_oe ? host_bus_out : 16'hFFFF);
	modport device (input link_clk, chip_select_n, output_enable_n, write_enable_n, address_valid_n,
		reset_n, upper_address_pins, host_bus_out, host_bus_oe, muxed_addr_data_bus,
		output ready, dev_bus_out, dev_bus_oe);
	modport host (output link_clk, chip_select_n, output_enable_n, write_enable_n, address_valid_n,
		reset_n, upper_address_pins, host_bus_out, host_bus_oe,
		input ready, dev_bus_out, dev_bus_oe, muxed_addr_data_bus);
endinterface

// ==== rtl/mxp_device.sv ====
// Functional notes
// RL1: Upper, lower, data share one 16-bit bus
// RL2: Word address is upper joined with lower
// RL3: Stored upper half reused when omitted
// RL4: Async: strobe rise captures upper/lower by OE
// RL5: Sync: clock edge captures upper/lower by OE
// RL6: CS high or OE after ready ends read
// RL7: Drive only after lower-address capture
// RL8: Host idles one clock before new upper
// RL9: Never drive bus during writes
// RL10: Reset upper to boot-end value
// RL11: Host picks boot sector for overlay; the TOP_BOOT parameter of mxp_device fixes it instead
// RL12: Asynchronous mode after reset
// RL13: Chip select high means high impedance
// RL14: Async write latches bus data
// RL15: Full mode: upper pins, lower bus
// RL16: Sync lower capture needs CS low, WE high
// RL17: Burst drives data, advances each clock
// RL18: No burst data before wait states
// RL19: Terminated burst releases bus
// RL20: Full async latches on strobe rise
// RL21: Async read drives read data
// RL22: Reset low keeps bus high impedance
module mxp_device import mxp_pkg::*; #(
	parameter logic TOP_BOOT = 1'b0
) (
	mxp_if.device link,
	input wire logic sync_mode,
	input wire logic full_mode,
	input wire logic [WAIT_W-1:0] wait_states,
	input wire logic [DATA_W-1:0] read_data,
	output logic [WORD_ADDR_W-1:0] access_addr,
	output logic [DATA_W-1:0] write_data,
	output logic write_strobe
);
	logic [ADDR_HALF_W-1:0] upper;
	logic [ADDR_HALF_W-1:0] lower;
	logic [DATA_W-1:0] dout;
	logic drive;
	logic armed;
	logic rdy_seen;
	logic [WAIT_W-1:0] wait_cnt;
	logic avd_q;
	logic oe_q;
	logic cs_q;
	logic rst_n;
	logic addr_edge;
	logic sample_addr;
	logic take_upper;
	logic take_lower;
	logic active;
	logic rd_cond;
	logic end_read;
	logic [ADDR_HALF_W-1:0] bus_q;
	logic [ADDR_HALF_W-1:0] cap_bus;
	logic sync_s1;
	logic sync_act;
	logic full_s1;
	logic full_act;
	logic wr_cond;

	assign rst_n = link.reset_n;
	// Async strobe rise seen on link clock; sync mode uses level with AVD low
	assign addr_edge = !avd_q && link.address_valid_n;
	assign sample_addr = sync_act ? !link.address_valid_n : addr_edge;
	assign active = !link.chip_select_n;
	// RL4 RL5 upper capture by OE low
	assign take_upper = active && sample_addr && !full_act
		&& (sync_act ? !link.output_enable_n && link.write_enable_n : !oe_q);
	// RL16 RL15 sync lower capture needs WE high
	assign take_lower = active && sample_addr
		&& (sync_act ? link.output_enable_n && link.write_enable_n : oe_q);
	assign rd_cond = active && !link.output_enable_n && link.write_enable_n && link.address_valid_n;
	// RL6 RL19 read termination
	assign end_read = !active || (rdy_seen && link.output_enable_n);
	// Async edge: bus value held while strobe was low
	assign cap_bus = sync_act ? link.muxed_addr_data_bus : bus_q;

	always_ff @(posedge link.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			avd_q <= 1'b1;
			oe_q <= 1'b1;
			cs_q <= 1'b1;
			bus_q <= '0;
		end else begin
			avd_q <= link.address_valid_n;
			oe_q <= link.output_enable_n;
			cs_q <= link.chip_select_n;
			bus_q <= link.muxed_addr_data_bus;
		end
	end

	// RL12 mode inputs cross in; async after reset
	always_ff @(posedge link.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_s1 <= 1'b0;
			sync_act <= 1'b0;
			full_s1 <= 1'b0;
			full_act <= 1'b0;
		end else begin
			sync_s1 <= sync_mode;
			sync_act <= sync_s1;
			full_s1 <= full_mode;
			full_act <= full_s1;
		end
	end

	// RL10 RL3 stored upper half
	always_ff @(posedge link.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			upper <= TOP_BOOT ? UPPER_RESET_TOP : UPPER_RESET_BOTTOM;
		end else if (take_upper) begin
			upper <= cap_bus;
		end else if (take_lower && full_act) begin
			// RL15 RL20 upper from pins
			upper <= ADDR_HALF_W'(link.upper_address_pins);
		end
	end

	// RL1 RL2 lower half and address join
	always_ff @(posedge link.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			lower <= '0;
		end else if (take_lower) begin
			lower <= cap_bus;
		end else if (sync_act && drive && rd_cond) begin
			// RL17 burst advance
			lower <= lower + 16'h0001;
		end
	end

	always_ff @(posedge link.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			access_addr <= '0;
		end else begin
			access_addr <= mxp_join(upper, lower);
		end
	end

	// RL7 arm output only after lower capture
	always_ff @(posedge link.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			armed <= 1'b0;
		end else if (take_lower) begin
			armed <= 1'b1;
		end else if (end_read || take_upper) begin
			armed <= 1'b0;
		end
	end

	// RL18 initial wait states, sync only
	always_ff @(posedge link.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_cnt <= '0;
		end else if (take_lower) begin
			wait_cnt <= sync_act ? wait_states : '0;
		end else if (wait_cnt != '0) begin
			wait_cnt <= wait_cnt - 4'h1;
		end
	end

	// RL6 ready seen in this access
	always_ff @(posedge link.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdy_seen <= 1'b0;
		end else if (take_lower || end_read || take_upper) begin
			rdy_seen <= 1'b0;
		end else if (drive) begin
			rdy_seen <= 1'b1;
		end
	end

	// RL9 RL13 RL21 RL17 drive control
	always_ff @(posedge link.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			drive <= 1'b0;
		end else begin
			drive <= armed && rd_cond && wait_cnt == '0 && !end_read;
		end
	end

	always_ff @(posedge link.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			dout <= '0;
		end else begin
			dout <= read_data;
		end
	end

	// RL22 high impedance while reset low
	assign link.dev_bus_oe = drive && rst_n && !link.chip_select_n;
	assign link.dev_bus_out = dout;
	assign link.ready = drive;

	// RL14 async write data latch
	assign wr_cond = !cs_q && active && !link.write_enable_n && link.output_enable_n
		&& link.address_valid_n && !drive;

	always_ff @(posedge link.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			write_strobe <= 1'b0;
		end else begin
			write_strobe <= wr_cond;
		end
	end

	always_ff @(posedge link.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			write_data <= '0;
		end else if (wr_cond) begin
			write_data <= link.muxed_addr_data_bus;
		end
	end
endmodule // mxp_device

// ==== rtl/mxp_host.sv ====
module mxp_host import mxp_pkg::*; (
	input wire logic ref_clk,
	input wire logic nrst,
	mxp_if.host link,
	input wire logic req,
	input wire logic req_write,
	input wire logic req_upper,
	input wire logic [WORD_ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	output logic busy,
	output logic [DATA_W-1:0] rdata,
	output logic rdata_valid
);
	typedef enum logic [2:0] {H_IDLE, H_UP, H_UP2, H_LO, H_RD, H_WR, H_GAP} mxp_hstate_type;
	mxp_hstate_type state;
	logic div;
	logic rdy_s1;
	logic rdy_s2;
	logic we;
	logic [WORD_ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wd;

	// Link clock from divider
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			div <= 1'b0;
		end else begin
			div <= !div;
		end
	end
	assign link.link_clk = div;
	assign link.reset_n = nrst;
	assign link.upper_address_pins = addr[ADDR_HALF_W+UPPER_PIN_W-1:ADDR_HALF_W];

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdy_s1 <= 1'b0;
			rdy_s2 <= 1'b0;
		end else begin
			rdy_s1 <= link.ready;
			rdy_s2 <= rdy_s1;
		end
	end

	// Steps on falling link edge (div 1->0)
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state <= H_IDLE;
			we <= 1'b0;
			addr <= '0;
			wd <= '0;
			rdata <= '0;
			rdata_valid <= 1'b0;
			busy <= 1'b0;
			link.chip_select_n <= 1'b1;
			link.output_enable_n <= 1'b1;
			link.write_enable_n <= 1'b1;
			link.address_valid_n <= 1'b1;
			link.host_bus_oe <= 1'b0;
			link.host_bus_out <= '0;
		end else begin
			rdata_valid <= 1'b0;
			if (div) begin
				unique case (state)
					H_IDLE: begin
						if (req) begin
							busy <= 1'b1;
							we <= req_write;
							addr <= req_addr;
							wd <= req_wdata;
							link.chip_select_n <= 1'b0;
							link.address_valid_n <= 1'b0;
							link.host_bus_oe <= 1'b1;
							// RL4 upper with OE low
							link.output_enable_n <= !req_upper;
							link.host_bus_out <= req_upper ? req_addr[WORD_ADDR_W-1:ADDR_HALF_W]
								: req_addr[ADDR_HALF_W-1:0];
							state <= req_upper ? H_UP : H_LO;
						end
					end
					H_UP: begin
						// RL4 strobe rise ends upper phase
						link.address_valid_n <= 1'b1;
						state <= H_UP2;
					end
					H_UP2: begin
						link.address_valid_n <= 1'b0;
						link.output_enable_n <= 1'b1;
						link.host_bus_out <= addr[ADDR_HALF_W-1:0];
						state <= H_LO;
					end
					H_LO: begin
						link.address_valid_n <= 1'b1;
						if (we) begin
							// RL14 write data phase
							link.host_bus_out <= wd;
							link.write_enable_n <= 1'b0;
							state <= H_WR;
						end else begin
							link.host_bus_oe <= 1'b0;
							link.output_enable_n <= 1'b0;
							state <= H_RD;
						end
					end
					H_RD: begin
						if (rdy_s2) begin
							rdata <= link.muxed_addr_data_bus;
							rdata_valid <= 1'b1;
							link.output_enable_n <= 1'b1;
							link.chip_select_n <= 1'b1;
							state <= H_GAP;
						end
					end
					H_WR: begin
						link.write_enable_n <= 1'b1;
						link.chip_select_n <= 1'b1;
						link.host_bus_oe <= 1'b0;
						state <= H_GAP;
					end
					H_GAP: begin
						// RL8 idle clock before next
						busy <= 1'b0;
						state <= H_IDLE;
					end
				endcase
			end
		end
	end
endmodule // mxp_host

// ==== test/mxp_monitor.sv ====
module mxp_monitor (
	input wire logic link_clk,
	input wire logic reset_n,
	input wire logic chip_select_n,
	input wire logic output_enable_n,
	input wire logic write_enable_n,
	input wire logic address_valid_n,
	input wire logic ready,
	input wire logic host_bus_oe,
	input wire logic dev_bus_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge link_clk); endclocking
	default disable iff (!reset_n);
	standby_quiet_a: assert property ($past(chip_select_n) && chip_select_n |-> !dev_bus_oe)
		else $error("device drives bus in standby");
	write_quiet_a: assert property (!write_enable_n |-> !dev_bus_oe)
		else $error("device drives bus during write");
	upper_quiet_a: assert property (!address_valid_n && !output_enable_n |-> !dev_bus_oe)
		else $error("device drives bus at upper capture");
	oe_release_a: assert property ($rose(output_enable_n) |-> ##[0:1] !dev_bus_oe)
		else $error("bus kept after output enable rose");
	cs_release_a: assert property ($rose(chip_select_n) |-> ##[0:1] !dev_bus_oe)
		else $error("bus kept after chip select rose");
	no_contention_a: assert property (!(dev_bus_oe && host_bus_oe))
		else $error("both ends drive the bus");
	read_answer_a: assert property (!chip_select_n && !output_enable_n && write_enable_n && address_valid_n
		|-> ##[0:40] (ready || chip_select_n))
		else $error("read phase without ready");
	idle_gap_a: assert property ($rose(chip_select_n) |=> chip_select_n)
		else $error("no idle clock between accesses");
	cover property (ready && dev_bus_oe);
	cover property (!write_enable_n && !chip_select_n);
	cover property (!address_valid_n && !output_enable_n && !chip_select_n);
endmodule // mxp_monitor

// ==== test/muxed_addr_data_host_port_test.sv ====
module muxed_addr_data_host_port_test;
	import mxp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic sync_mode = 1'b0;
	logic full_mode = 1'b0;
	logic [WAIT_W-1:0] wait_states = WAIT_STATES_DEFAULT;
	logic [DATA_W-1:0] read_data = 16'h0000;
	logic req = 1'b0;
	logic req_write = 1'b0;
	logic req_upper = 1'b0;
	logic [WORD_ADDR_W-1:0] req_addr = 32'h00000000;
	logic [DATA_W-1:0] req_wdata = 16'h0000;
	logic busy, rdata_valid, write_strobe;
	logic [DATA_W-1:0] rdata, write_data;
	logic [WORD_ADDR_W-1:0] access_addr;
	int err_count = 0;
	int checks = 0;
	int cycles = 0;
	mxp_if link();
	mxp_device #(.TOP_BOOT(1'b0)) mxp_device_inst (.link(link), .sync_mode(sync_mode), .full_mode(full_mode),
		.wait_states(wait_states), .read_data(read_data), .access_addr(access_addr), .write_data(write_data),
		.write_strobe(write_strobe));
	mxp_host mxp_host_inst (.ref_clk(ref_clk), .nrst(nrst), .link(link), .req(req), .req_write(req_write),
		.req_upper(req_upper), .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy), .rdata(rdata),
		.rdata_valid(rdata_valid));
	mxp_monitor mxp_monitor_inst (.link_clk(link.link_clk), .reset_n(link.reset_n),
		.chip_select_n(link.chip_select_n), .output_enable_n(link.output_enable_n),
		.write_enable_n(link.write_enable_n), .address_valid_n(link.address_valid_n), .ready(link.ready),
		.host_bus_oe(link.host_bus_oe), .dev_bus_oe(link.dev_bus_oe));
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic access(input logic w, input logic u, input logic [31:0] a, input logic [15:0] d,
		input logic [31:0] ea);
		int n;
		logic seen;
		logic [15:0] got;
		n = 0;
		seen = 1'b0;
		got = 16'h0000;
		@(negedge ref_clk);
		read_data = d;
		req_write = w;
		req_upper = u;
		req_addr = a;
		req_wdata = d;
		req = 1'b1;
		while (busy !== 1'b1 && n < 50) begin
			@(negedge ref_clk);
			n++;
		end
		req = 1'b0;
		while ((busy !== 1'b0 || !seen) && n < 400) begin
			@(negedge ref_clk);
			n++;
			if (rdata_valid === 1'b1 && !w) begin
				seen = 1'b1;
				got = rdata;
			end
			if (write_strobe === 1'b1 && w) begin
				seen = 1'b1;
				got = write_data;
			end
		end
		chk({31'h0, seen}, 32'h00000001);
		chk(access_addr, ea);
		chk({16'h0, got}, {16'h0, d});
	endtask
	task automatic boot_read();
		access(1'b0, 1'b0, 32'hFFFF0123, 16'h1357, 32'h00000123);
		access(1'b0, 1'b0, 32'h0000FFF0, 16'h4242, 32'h0000FFF0);
	endtask
	task automatic split_reads();
		access(1'b0, 1'b1, 32'hABCD0010, 16'h2468, 32'hABCD0010);
		access(1'b0, 1'b0, 32'h00000020, 16'h9BDF, 32'hABCD0020);
	endtask
	task automatic write_cycle();
		access(1'b1, 1'b1, 32'h12340040, 16'h5AA5, 32'h12340040);
	endtask
	task automatic sync_reads();
		sync_mode = 1'b1;
		repeat (8) @(negedge ref_clk);
		access(1'b0, 1'b1, 32'h00560070, 16'hCAFE, 32'h00560071);
		access(1'b0, 1'b0, 32'h00000071, 16'h0F0F, 32'h00560072);
		sync_mode = 1'b0;
	endtask
	task automatic full_reads();
		full_mode = 1'b1;
		repeat (8) @(negedge ref_clk);
		access(1'b0, 1'b0, 32'h01550040, 16'h3C3C, 32'h01550040);
		sync_mode = 1'b1;
		repeat (8) @(negedge ref_clk);
		access(1'b0, 1'b0, 32'h00AA0044, 16'hA5C3, 32'h00AA0045);
		sync_mode = 1'b0;
		full_mode = 1'b0;
	endtask
	task automatic second_reset();
		@(negedge ref_clk);
		nrst = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk({31'h0, link.dev_bus_oe}, 32'h00000000);
		nrst = 1'b1;
		access(1'b0, 1'b0, 32'h00000300, 16'h7777, 32'h00000300);
	endtask
	task automatic finish_test();
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge ref_clk);
		nrst = 1'b1;
		@(negedge ref_clk);
		boot_read();
		split_reads();
		write_cycle();
		sync_reads();
		full_reads();
		second_reset();
		finish_test();
	end
endmodule // muxed_addr_data_host_port_test
